/* File: hw/irap_defines.svh */
// register map, field layout, reset values and timing figures of the ir ambient parameter block
`ifndef IRAP_DEFINES_SVH
`define IRAP_DEFINES_SVH
// =====================================================================
// register indices (byte address is four times the index)
`define IRAP_IDX_OFFSET 8'h1a
`define IRAP_IDX_LED_RECOVERY_FIELD 8'h1c
`define IRAP_IDX_IR_COUNTER 8'h1d
`define IRAP_IDX_IR_GAIN 8'h1e
`define IRAP_IDX_IR_MISC 8'h1f
// =====================================================================
// reset values
`define IRAP_RST_OFFSET 8'h80
`define IRAP_RST_LED_RECOVERY_FIELD 8'h00
`define IRAP_RST_IR_COUNTER 8'h70
`define IRAP_RST_IR_GAIN 8'h00
`define IRAP_RST_IR_MISC 8'h00
// =====================================================================
// field positions
`define IRAP_REC_MSB 6
`define IRAP_REC_LSB 4
`define IRAP_GAIN_MSB 2
`define IRAP_RANGE_BIT 5
// =====================================================================
// values and timing
`define IRAP_OVERRANGE 16'hffff
`define IRAP_MAX_LEGIT 16'hfffe
`define IRAP_ADC_CLK_NS 50
`define IRAP_SYS_CLK_NS 10
`define IRAP_ADC_CLK_CYC ((`IRAP_ADC_CLK_NS + `IRAP_SYS_CLK_NS - 1) / `IRAP_SYS_CLK_NS)
`define IRAP_FIRST_IR_REV 3
`endif

/* File: hw/irap_pkg.sv */
// types shared by the ir ambient parameter block
package irap_pkg;
  typedef enum logic [1:0] {
    IRAP_IDLE,
    IRAP_RECOVER,
    IRAP_INTEGRATE,
    IRAP_REPORT
  } irap_state_type;
endpackage

/* File: hw/irap_offset_expand.sv */
// expands the 8-bit compressed offset into its 16-bit value
module irap_offset_expand
  import irap_pkg::*;
(
  // compressed code
  input wire logic [7:0] code_in,
  // expanded value
  output logic [15:0] value_out
);
  logic [19:0] shifted;

  // upper nibble is the exponent, lower nibble the mantissa below an implied one
  always_comb begin
    shifted = {15'h0000, 1'b1, code_in[3:0]} << code_in[7:4];
    value_out = shifted[19:4];
  end
endmodule

/* File: hw/irap_top.sv */
// ir ambient measurement parameters: apb register file and measurement sequencer
// =====================================================================
//
// Design decision made here: register access over APB.
`include "irap_defines.svh"

module irap_top
  import irap_pkg::*;
#(
  parameter int SEQ_REVISION = 3,
  parameter int INTEG_CLOCKS = 256
)
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // measurement request and adc converter data
  input wire logic meas_start_in,
  input wire logic [15:0] adc_raw_in,
  input wire logic adc_overrange_in,
  // visible parameters used by older sequencers
  input wire logic [2:0] vis_gain_in,
  input wire logic vis_range_in,
  // measurement status and result
  output logic busy_out,
  output logic recovering_out,
  output logic integrating_out,
  output logic [2:0] ir_gain_out,
  output logic ir_high_range_out,
  output logic [15:0] result_out,
  output logic result_valid_out
);
  localparam int ADC_CLK_CYC = `IRAP_ADC_CLK_CYC;
  localparam int REC_W = 9;
  localparam int INT_W = 16;
  localparam bit IR_PARAMS_ON = (SEQ_REVISION >= `IRAP_FIRST_IR_REV);
  localparam logic [7:0] RST_COUNTER = `IRAP_RST_IR_COUNTER;
  localparam logic [7:0] RST_GAIN = `IRAP_RST_IR_GAIN;

  if (INTEG_CLOCKS < 1 || INTEG_CLOCKS > 65535) begin : g_bad_integ
    $error("INTEG_CLOCKS out of range");
  end
  if (ADC_CLK_CYC < 1) begin : g_bad_adc_clk
    $error("adc clock shorter than one system cycle");
  end

  // =====================================================================
  // registers
  logic [7:0] meas_offset;
  logic [7:0] led_recovery_field;
  logic [2:0] ir_recovery_period;
  logic [2:0] ir_integration_gain;
  logic [7:0] ir_misc_param;
  logic [15:0] offset_exp;
  irap_state_type state;
  logic [2:0] gain_lat;
  logic [REC_W-1:0] rec_target;
  logic [11:0] presc;
  logic [INT_W-1:0] tick_cnt;
  logic adc_tick;
  logic [11:0] tick_period;

  // =====================================================================
  // apb slave
  logic [9:0] word_idx;
  logic access;
  logic hit;
  logic [31:0] rd_mux;

  assign word_idx = paddr_in[11:2];
  assign access = psel_in && penable_in;

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (word_idx)
      {2'b00, `IRAP_IDX_OFFSET}: rd_mux[7:0] = meas_offset;
      {2'b00, `IRAP_IDX_LED_RECOVERY_FIELD}: rd_mux[7:0] = led_recovery_field;
      {2'b00, `IRAP_IDX_IR_COUNTER}: rd_mux[`IRAP_REC_MSB:`IRAP_REC_LSB] = ir_recovery_period;
      {2'b00, `IRAP_IDX_IR_GAIN}: rd_mux[`IRAP_GAIN_MSB:0] = ir_integration_gain;
      {2'b00, `IRAP_IDX_IR_MISC}: rd_mux[7:0] = ir_misc_param;
      default: hit = 1'b0;
    endcase
  end

  // answer in the second access cycle, so pready comes straight from a flop
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= access && !pready_out;
      pslverr_out <= access && !pready_out && !hit;
      if (access && !pready_out && !pwrite_in && hit) begin
        prdata_out <= rd_mux;
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  logic wr_en;
  assign wr_en = access && pready_out && pwrite_in;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meas_offset <= `IRAP_RST_OFFSET;
      led_recovery_field <= `IRAP_RST_LED_RECOVERY_FIELD;
      ir_recovery_period <= RST_COUNTER[`IRAP_REC_MSB:`IRAP_REC_LSB];
      ir_integration_gain <= RST_GAIN[`IRAP_GAIN_MSB:0];
      ir_misc_param <= `IRAP_RST_IR_MISC;
    end else if (wr_en) begin
      case (word_idx)
        {2'b00, `IRAP_IDX_OFFSET}: meas_offset <= pwdata_in[7:0];
        {2'b00, `IRAP_IDX_LED_RECOVERY_FIELD}: led_recovery_field <= pwdata_in[7:0];
        // reserved bits of the counter byte are not stored and read as zero
        {2'b00, `IRAP_IDX_IR_COUNTER}: ir_recovery_period <= pwdata_in[`IRAP_REC_MSB:`IRAP_REC_LSB];
        {2'b00, `IRAP_IDX_IR_GAIN}: ir_integration_gain <= pwdata_in[`IRAP_GAIN_MSB:0];
        // whole byte kept so a read-modify-write round-trips the reserved bits
        {2'b00, `IRAP_IDX_IR_MISC}: ir_misc_param <= pwdata_in[7:0];
        default: ;
      endcase
    end
  end

  // =====================================================================
  // offset expansion
  irap_offset_expand u_expand (
    .code_in(meas_offset),
    .value_out(offset_exp)
  );

  // =====================================================================
  // recovery length per code
  function automatic logic [REC_W-1:0] rec_clocks(input logic [2:0] code);
    logic [REC_W-1:0] r;
    r = 9'h001;
    case (code)
      3'h0: r = 9'h001;
      3'h1: r = 9'h007;
      3'h2: r = 9'h00f;
      3'h3: r = 9'h01f;
      3'h4: r = 9'h03f;
      3'h5: r = 9'h07f;
      3'h6: r = 9'h0ff;
      default: r = 9'h1ff;
    endcase
    return r;
  endfunction

  // =====================================================================
  // adc clock divider: base 50 ns clock divided by two to the gain
  assign tick_period = 12'(ADC_CLK_CYC) << gain_lat;
  assign adc_tick = (presc == tick_period - 12'h001);

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      presc <= 12'h000;
    end else if (state == IRAP_IDLE || adc_tick) begin
      presc <= 12'h000;
    end else begin
      presc <= presc + 12'h001;
    end
  end

  // =====================================================================
  // sequencer
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= IRAP_IDLE;
      gain_lat <= 3'h0;
      rec_target <= 9'h001;
      tick_cnt <= 16'h0000;
      ir_gain_out <= 3'h0;
      ir_high_range_out <= 1'b0;
    end else begin
      case (state)
        IRAP_IDLE: begin
          tick_cnt <= 16'h0000;
          if (meas_start_in) begin
            state <= IRAP_RECOVER;
            // older sequencers run ir from the visible settings and skip the long recovery
            if (IR_PARAMS_ON) begin
              gain_lat <= ir_integration_gain;
              ir_gain_out <= ir_integration_gain;
              rec_target <= rec_clocks(ir_recovery_period);
              ir_high_range_out <= ir_misc_param[`IRAP_RANGE_BIT];
            end else begin
              gain_lat <= vis_gain_in;
              ir_gain_out <= vis_gain_in;
              rec_target <= 9'h001;
              ir_high_range_out <= vis_range_in;
            end
          end
        end
        IRAP_RECOVER: begin
          if (adc_tick) begin
            if (tick_cnt == 16'(rec_target) - 16'h0001) begin
              state <= IRAP_INTEGRATE;
              tick_cnt <= 16'h0000;
            end else begin
              tick_cnt <= tick_cnt + 16'h0001;
            end
          end
        end
        IRAP_INTEGRATE: begin
          // integration counts divided adc clocks, so it grows by two to the gain
          if (adc_tick) begin
            if (tick_cnt == 16'(INTEG_CLOCKS - 1)) begin
              state <= IRAP_REPORT;
              tick_cnt <= 16'h0000;
            end else begin
              tick_cnt <= tick_cnt + 16'h0001;
            end
          end
        end
        IRAP_REPORT: state <= IRAP_IDLE;
        default: state <= IRAP_IDLE;
      endcase
    end
  end

  // =====================================================================
  // result: raw relative value plus offset, clamped away from the overrange code
  logic signed [17:0] sum;
  assign sum = 18'(signed'(adc_raw_in)) + 18'(signed'({2'b00, offset_exp}));

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      result_out <= 16'h0000;
      result_valid_out <= 1'b0;
    end else begin
      result_valid_out <= (state == IRAP_REPORT);
      if (state == IRAP_REPORT) begin
        if (adc_overrange_in) begin
          result_out <= `IRAP_OVERRANGE;
        end else if (sum < 18'sd0) begin
          result_out <= 16'h0000;
        end else if (sum > 18'(`IRAP_MAX_LEGIT)) begin
          result_out <= `IRAP_MAX_LEGIT;
        end else begin
          result_out <= sum[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b0;
      recovering_out <= 1'b0;
      integrating_out <= 1'b0;
    end else begin
      busy_out <= (state != IRAP_IDLE) || meas_start_in;
      recovering_out <= (state == IRAP_RECOVER);
      integrating_out <= (state == IRAP_INTEGRATE);
    end
  end

  // =====================================================================
  // checks
  logic [15:0] chk_rec_ticks;
  logic [11:0] chk_gap;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chk_rec_ticks <= 16'h0000;
      chk_gap <= 12'h000;
    end else begin
      if (state != IRAP_RECOVER) begin
        chk_rec_ticks <= 16'h0000;
      end else if (adc_tick) begin
        chk_rec_ticks <= chk_rec_ticks + 16'h0001;
      end
      chk_gap <= (adc_tick || state == IRAP_IDLE) ? 12'h000 : chk_gap + 12'h001;
    end
  end

  chk_offset_reset: assert property (@(posedge clk_sys_in) $fell(sys_rst_in) |-> meas_offset == 8'h80)
    else $error("offset not at default after reset");
  chk_counter_reset: assert property (@(posedge clk_sys_in) $fell(sys_rst_in) |-> ir_recovery_period == 3'h7)
    else $error("recovery not at default after reset");
  chk_offset_decode: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (meas_offset == 8'h60 |-> offset_exp == 16'h0040) and (meas_offset == 8'h70 |-> offset_exp == 16'h0080)
    and (meas_offset == 8'h80 |-> offset_exp == 16'h0100))
    else $error("offset code decoded wrongly");
  chk_result_sum: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    state == IRAP_REPORT && !adc_overrange_in && adc_raw_in < 16'h8000
    && (17'(adc_raw_in) + 17'(offset_exp)) < 17'h0ffff
    |=> result_valid_out && result_out == $past(adc_raw_in) + $past(offset_exp))
    else $error("result is not raw plus offset");
  chk_overrange_code: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    state == IRAP_REPORT && adc_overrange_in |=> result_out == 16'hffff)
    else $error("overrange not reported as all ones");
  chk_legit_not_ovr: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    result_valid_out && !$past(adc_overrange_in) |-> result_out != 16'hffff)
    else $error("legitimate result collides with overrange code");
  chk_recovery_len: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    state == IRAP_RECOVER ##1 state == IRAP_INTEGRATE |-> $past(chk_rec_ticks) == 16'(rec_target) - 16'h0001)
    else $error("recovery length wrong");
  chk_tick_period: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    adc_tick |-> chk_gap == (12'h005 << gain_lat) - 12'h001)
    else $error("adc clock period wrong");
  chk_rev_gate: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    state == IRAP_IDLE && meas_start_in |=> ir_high_range_out ==
    (IR_PARAMS_ON ? $past(ir_misc_param[5]) : $past(vis_range_in)))
    else $error("range not taken from the right parameter");
endmodule

/* File: verif/irap_adc_model.sv */
// converter data source standing behind the sequencer's raw result inputs
module irap_adc_model
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // sequencer status and the sample to present
  input wire logic busy_in,
  input wire logic [15:0] sample_in,
  input wire logic over_in,
  // converter outputs
  output logic [15:0] adc_raw_out,
  output logic adc_overrange_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // data source
  // outside a measurement the data flips every cycle, so a late sample cannot pass by luck
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      adc_raw_out <= 16'h0000;
      adc_overrange_out <= 1'b0;
    end else if (busy_in) begin
      adc_raw_out <= sample_in;
      adc_overrange_out <= over_in;
    end else begin
      adc_raw_out <= ~adc_raw_out;
      adc_overrange_out <= ~adc_overrange_out;
    end
  end
endmodule

/* File: verif/test_irap_top.sv */
// self-checking bench of the ir ambient parameter block with its converter model
`include "irap_defines.svh"
`define CHECK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module test_irap_top
  import irap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // signals and tables
  // a short integration keeps the long recovery codes affordable in simulation
  localparam int INTEG = 4;
  typedef struct packed {logic [7:0] idx; logic [7:0] wr; logic [7:0] rd; logic [7:0] rst;} irap_reg_row_type;
  typedef struct packed {
    logic [7:0] off; logic [7:0] cnt; logic [2:0] gain; logic rng;
    logic [15:0] raw; logic ovr; logic [15:0] res; int clocks;
  } irap_meas_row_type;
  int mismatches = 0;
  int num_checks = 0;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic meas_start_in = 1'b0;
  logic [15:0] sample = 16'h0000;
  logic over = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, busy_out, recovering_out, integrating_out;
  logic [2:0] ir_gain_out;
  logic ir_high_range_out, result_valid_out, adc_overrange_in;
  logic [15:0] result_out, adc_raw_in;
  irap_reg_row_type reg_rows [5] = '{
    '{`IRAP_IDX_OFFSET, 8'ha5, 8'ha5, `IRAP_RST_OFFSET},
    '{`IRAP_IDX_LED_RECOVERY_FIELD, 8'h5a, 8'h5a, `IRAP_RST_LED_RECOVERY_FIELD},
    '{`IRAP_IDX_IR_COUNTER, 8'hff, 8'h70, `IRAP_RST_IR_COUNTER},
    '{`IRAP_IDX_IR_GAIN, 8'hff, 8'h07, `IRAP_RST_IR_GAIN},
    '{`IRAP_IDX_IR_MISC, 8'hc3, 8'hc3, `IRAP_RST_IR_MISC}};
  irap_meas_row_type meas_rows [9] = '{
    '{8'h80, 8'h00, 3'h5, 1'b0, 16'h0010, 1'b0, 16'h0110, 1},
    '{8'h60, 8'h10, 3'h6, 1'b1, 16'hfff0, 1'b0, 16'h0030, 7},
    '{8'h70, 8'h20, 3'h4, 1'b0, 16'h0005, 1'b1, 16'hffff, 15},
    '{8'h80, 8'h30, 3'h0, 1'b1, 16'hfe00, 1'b0, 16'h0000, 31},
    '{8'hff, 8'h40, 3'h1, 1'b0, 16'h7fff, 1'b0, 16'hfffe, 63},
    '{8'h80, 8'h50, 3'h2, 1'b0, 16'h0000, 1'b0, 16'h0100, 127},
    '{8'h70, 8'h60, 3'h3, 1'b1, 16'h0001, 1'b0, 16'h0081, 255},
    '{8'h60, 8'h70, 3'h0, 1'b0, 16'h0002, 1'b0, 16'h0042, 511},
    '{8'h70, 8'h00, 3'h7, 1'b1, 16'h0003, 1'b0, 16'h0083, 1}};
  // =====================================================================
  // design and converter model
  irap_top #(.SEQ_REVISION(3), .INTEG_CLOCKS(INTEG)) u_irap_top (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .meas_start_in(meas_start_in), .adc_raw_in(adc_raw_in), .adc_overrange_in(adc_overrange_in),
    .vis_gain_in(3'h0), .vis_range_in(1'b0),
    .busy_out(busy_out), .recovering_out(recovering_out), .integrating_out(integrating_out),
    .ir_gain_out(ir_gain_out), .ir_high_range_out(ir_high_range_out),
    .result_out(result_out), .result_valid_out(result_valid_out));
  irap_adc_model u_irap_adc_model (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .busy_in(busy_out),
    .sample_in(sample), .over_in(over),
    .adc_raw_out(adc_raw_in), .adc_overrange_out(adc_overrange_in));
  // =====================================================================
  // tasks
  task automatic close_out();
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // entered right after a rising edge; leaves one idle cycle so no signal is driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= {2'b00, idx, 2'b00};
    pwdata_in <= wdata;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 100);
    if (pready_out !== 1'b1) mismatches++;
    rdata = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic measure(input irap_meas_row_type m);
    logic [31:0] rd;
    logic err;
    int rec;
    int itg;
    int n;
    int tick;
    rec = 0;
    itg = 0;
    n = 0;
    tick = `IRAP_ADC_CLK_CYC * (1 << m.gain);
    apb(1'b1, `IRAP_IDX_OFFSET, {24'h0, m.off}, rd, err);
    apb(1'b1, `IRAP_IDX_IR_COUNTER, {24'h0, m.cnt}, rd, err);
    apb(1'b1, `IRAP_IDX_IR_GAIN, {29'h0, m.gain}, rd, err);
    apb(1'b0, `IRAP_IDX_IR_MISC, 32'h0, rd, err);
    apb(1'b1, `IRAP_IDX_IR_MISC, {rd[31:6], m.rng, rd[4:0]}, rd, err);
    sample <= m.raw;
    over <= m.ovr;
    meas_start_in <= 1'b1;
    @(posedge clk_sys_in);
    meas_start_in <= 1'b0;
    do begin
      @(posedge clk_sys_in);
      if (recovering_out === 1'b1) rec++;
      if (integrating_out === 1'b1) itg++;
      n++;
    end while (result_valid_out !== 1'b1 && n < 90000);
    if (result_valid_out !== 1'b1) mismatches++;
    `CHECK(busy_out, 1'b1)
    `CHECK(result_out, m.res)
    `CHECK(rec, tick * m.clocks)
    `CHECK(itg, tick * INTEG)
    `CHECK(ir_gain_out, m.gain)
    `CHECK(ir_high_range_out, m.rng)
    @(posedge clk_sys_in);
    `CHECK(busy_out, 1'b0)
  endtask
  // =====================================================================
  // clock, watchdog and main sequence
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #1000000;
    mismatches++;
    close_out();
  end
  initial begin
    logic [31:0] rd;
    logic err;
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    // upper write bits are set to show they are ignored
    foreach (reg_rows[i]) begin
      apb(1'b1, reg_rows[i].idx, {24'hffffff, reg_rows[i].wr}, rd, err);
      apb(1'b0, reg_rows[i].idx, 32'h0, rd, err);
      `CHECK(rd, {24'h0, reg_rows[i].rd})
      `CHECK(err, 1'b0)
    end
    foreach (meas_rows[i]) measure(meas_rows[i]);
    apb(1'b1, 8'h20, 32'h5a, rd, err);
    `CHECK(err, 1'b1)
    apb(1'b0, 8'h20, 32'h0, rd, err);
    `CHECK(rd, 32'h0)
    `CHECK(err, 1'b1)
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    `CHECK(result_out, 16'h0000)
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    foreach (reg_rows[i]) begin
      apb(1'b0, reg_rows[i].idx, 32'h0, rd, err);
      `CHECK(rd, {24'h0, reg_rows[i].rst})
    end
    close_out();
  end
endmodule
